// >>> inc/therm_pkg.sv
// Constants, carriers and state types for the thermostat alarm block.
// Operation
// - Compare each stored result against both limits
// - Polarity bit and mode bit shape alarm
// - Reset loads volatile settings from nonvolatile copies
// - Fault when at/above upper or at/below lower
// - Queue depth one, two, four or six
// - Counter counts faults, clean sample clears it
// - Comparator: upper valid fault asserts alarm
// - Comparator: lower valid fault releases alarm
// - Comparator: accesses and shutdown leave alarm alone
// - Interrupt to comparator keeps alarm until low
// - General call reset: alarm off, reload config
// - Interrupt: alarm holds until read, alert-ack, shutdown
// - Interrupt: armed event alternates upper then lower
// - Interrupt: first assertion needs upper event
// - Shutdown stops measurements, clearing resumes them
// - Shutdown entry clears alarm in interrupt mode
// - Fault counter survives shutdown, cleared by reset
// - Shutdown exit asserts matching pending interrupt event
// - Nonvolatile shutdown: load, measure once, sleep
// - One-shot while shut down measures once
// - One-shot fault: comparator level, interrupt pulse
// - Outside shutdown convert continuously, update temperature
package therm_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 3;
  localparam int PULSE_W = 8;

  // Register map, printed offsets used directly on the plain port
  localparam logic [ADDR_W-1:0] TEMP_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h01;
  localparam logic [ADDR_W-1:0] TLOW_ADDR = 8'h02;
  localparam logic [ADDR_W-1:0] THIGH_ADDR = 8'h03;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 8'h04;

  // Configuration word layout (same layout for the nonvolatile copy)
  localparam int CFG_SD_BIT = 0;
  localparam int CFG_MODE_BIT = 1;
  localparam int CFG_POL_BIT = 2;
  localparam int CFG_FQ_LSB_BIT = 3;
  localparam int CFG_FQ_MSB_BIT = 4;
  localparam int CFG_OS_BIT = 7;

  localparam logic MODE_CMP = 1'b0;
  localparam logic MODE_INT = 1'b1;

  localparam logic [CNT_W-1:0] FQ_DEPTH_1 = 3'h1;
  localparam logic [CNT_W-1:0] FQ_DEPTH_2 = 3'h2;
  localparam logic [CNT_W-1:0] FQ_DEPTH_4 = 3'h4;
  localparam logic [CNT_W-1:0] FQ_DEPTH_6 = 3'h6;
  localparam logic [CNT_W-1:0] CNT_MAX = 3'h6;
  localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;

  localparam logic [DATA_W-1:0] TEMP_RESET = 16'h0000;
  localparam int ONESHOT_PULSE_CYCLES = 4;

  typedef enum logic [1:0] {S_LOAD, S_IDLE, S_CONV} seq_t;

  typedef struct packed {
    logic fault_queue_sel_msb;
    logic fault_queue_sel_lsb;
    logic alarm_active_level;
    logic thermostat_mode_select;
    logic shutdown_select;
  } cfg_t;

  typedef struct packed {
    logic hit_high;
    logic hit_low;
  } cmp_t;

  typedef struct packed {
    logic done;
    logic valid_high;
    logic valid_low;
  } verdict_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    verdict_t verdict;
  } fq_state_t;

  typedef struct packed {
    seq_t seq;
    cfg_t cfg;
    logic [DATA_W-1:0] temp;
    logic [DATA_W-1:0] tlow;
    logic [DATA_W-1:0] thigh;
    logic [DATA_W-1:0] rdata;
    logic os_pend;
    logic boot_once;
    logic single;
    logic sd_prev;
    logic active;
    logic armed_low;
    logic last_vhigh;
    logic last_vlow;
    logic conv_start;
    logic alarm_pin;
    logic [PULSE_W-1:0] pulse_cnt;
  } main_state_t;

endpackage : therm_pkg

// >>> hdl/fault_queue.sv
// Consecutive-fault counter and valid-fault verdict.
`timescale 1ns/1ns
module fault_queue (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic sample,
  input wire therm_pkg::cmp_t hit,
  input wire logic [1:0] queue_sel,
  output therm_pkg::verdict_t verdict,
  output logic [therm_pkg::CNT_W-1:0] count
);

  therm_pkg::fq_state_t fq_reg;
  therm_pkg::fq_state_t fq_next;
  logic [therm_pkg::CNT_W-1:0] depth;
  logic [therm_pkg::CNT_W-1:0] bumped;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    case (queue_sel)
      2'h0: depth = therm_pkg::FQ_DEPTH_1;
      2'h1: depth = therm_pkg::FQ_DEPTH_2;
      2'h2: depth = therm_pkg::FQ_DEPTH_4;
      default: depth = therm_pkg::FQ_DEPTH_6;
    endcase
    // Saturate so a long excursion keeps re-declaring the fault
    bumped = (fq_reg.count == therm_pkg::CNT_MAX) ? fq_reg.count
           : fq_reg.count + therm_pkg::CNT_ONE;
    fq_next = fq_reg;
    fq_next.verdict = '0;
    if (clear) begin
      fq_next = '0;
    end else if (sample) begin
      fq_next.verdict.done = 1'b1;
      if (hit.hit_high || hit.hit_low) begin
        fq_next.count = bumped;
        fq_next.verdict.valid_high = hit.hit_high && (bumped >= depth);
        fq_next.verdict.valid_low = hit.hit_low && !hit.hit_high && (bumped >= depth);
      end else begin
        fq_next.count = '0;
      end
    end
    // No shutdown term here: the count rides through shutdown
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fq_reg <= '0;
    end else begin
      fq_reg <= fq_next;
    end
  end

  assign verdict = fq_reg.verdict;
  assign count = fq_reg.count;

  ////////////////////////////////////////////////////////////////////////////

  count_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    sample && !clear && !hit.hit_high && !hit.hit_low |=> count == '0)
    else $error("fault count not cleared by clean sample");

  queue_short_a: assert property (@(posedge mclk) disable iff (!resetn)
    sample && !clear && hit.hit_high && ({1'b0, fq_reg.count} + 4'h1 < {1'b0, depth})
    |=> !verdict.valid_high)
    else $error("valid fault before queue depth reached");

endmodule : fault_queue

// >>> hdl/temp_alarm_thermostat.sv
// Thermostat alarm: limit compare, alarm modes, shutdown and one-shot.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module temp_alarm_thermostat #(
  parameter int PULSE_CYCLES = therm_pkg::ONESHOT_PULSE_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [therm_pkg::ADDR_W-1:0] addr,
  input wire logic [therm_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [therm_pkg::DATA_W-1:0] rdata,
  input wire logic [therm_pkg::DATA_W-1:0] nv_config,
  input wire logic [therm_pkg::DATA_W-1:0] nv_tlow,
  input wire logic [therm_pkg::DATA_W-1:0] nv_thigh,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic [therm_pkg::DATA_W-1:0] conv_result,
  input wire logic gc_reset,
  input wire logic ara_ack,
  output logic alarm_pin
);

  localparam logic [therm_pkg::PULSE_W-1:0] PULSE_LOAD = therm_pkg::PULSE_W'(PULSE_CYCLES);
  localparam logic [therm_pkg::PULSE_W-1:0] PULSE_ONE = 8'h01;
  localparam int PULSE_MAX_A = 256;

  therm_pkg::main_state_t st_reg;
  therm_pkg::main_state_t st_next;
  therm_pkg::cmp_t hit;
  therm_pkg::verdict_t fq_v;
  logic [therm_pkg::CNT_W-1:0] fq_count;
  logic sample;
  logic int_mode;
  logic sd_rise;
  logic sd_fall;
  logic set_ev;

  ////////////////////////////////////////////////////////////////////////////
  // Limit compare on the fresh result, two's complement

  assign hit.hit_high = $signed(conv_result) >= $signed(st_reg.thigh);
  assign hit.hit_low = $signed(conv_result) <= $signed(st_reg.tlow);
  assign sample = (st_reg.seq == therm_pkg::S_CONV) && conv_done;

  assign int_mode = st_reg.cfg.thermostat_mode_select == therm_pkg::MODE_INT;
  assign sd_rise = st_reg.cfg.shutdown_select && !st_reg.sd_prev;
  assign sd_fall = !st_reg.cfg.shutdown_select && st_reg.sd_prev;

  // Reset clears the counter; general call reset acts as a reset here too
  fault_queue u_fault_queue (
    .mclk(mclk),
    .resetn(resetn),
    .clear(gc_reset),
    .sample(sample),
    .hit(hit),
    .queue_sel({st_reg.cfg.fault_queue_sel_msb, st_reg.cfg.fault_queue_sel_lsb}),
    .verdict(fq_v),
    .count(fq_count)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_next = st_reg;
    st_next.conv_start = 1'b0;
    st_next.rdata = '0;
    st_next.sd_prev = st_reg.cfg.shutdown_select;
    set_ev = 1'b0;

    // Conversion sequencer
    case (st_reg.seq)
      therm_pkg::S_LOAD: begin
        st_next.cfg.shutdown_select = nv_config[therm_pkg::CFG_SD_BIT];
        st_next.cfg.thermostat_mode_select = nv_config[therm_pkg::CFG_MODE_BIT];
        st_next.cfg.alarm_active_level = nv_config[therm_pkg::CFG_POL_BIT];
        st_next.cfg.fault_queue_sel_lsb = nv_config[therm_pkg::CFG_FQ_LSB_BIT];
        st_next.cfg.fault_queue_sel_msb = nv_config[therm_pkg::CFG_FQ_MSB_BIT];
        st_next.tlow = nv_tlow;
        st_next.thigh = nv_thigh;
        // Boot into shutdown still takes one reading first
        st_next.boot_once = nv_config[therm_pkg::CFG_SD_BIT];
        st_next.sd_prev = nv_config[therm_pkg::CFG_SD_BIT];
        st_next.os_pend = 1'b0;
        st_next.active = 1'b0;
        st_next.armed_low = 1'b0;
        st_next.last_vhigh = 1'b0;
        st_next.last_vlow = 1'b0;
        st_next.pulse_cnt = '0;
        st_next.seq = therm_pkg::S_IDLE;
      end
      therm_pkg::S_IDLE: begin
        // Shutdown holds the converter idle unless a single reading is owed
        if (!st_reg.cfg.shutdown_select || st_reg.boot_once || st_reg.os_pend) begin
          st_next.conv_start = 1'b1;
          st_next.single = st_reg.cfg.shutdown_select || st_reg.boot_once;
          st_next.boot_once = 1'b0;
          st_next.os_pend = 1'b0;
          st_next.seq = therm_pkg::S_CONV;
        end
      end
      therm_pkg::S_CONV: begin
        if (conv_done) begin
          st_next.temp = conv_result;
          st_next.seq = therm_pkg::S_IDLE;
        end
      end
      default: begin
        st_next.seq = therm_pkg::S_LOAD;
      end
    endcase

    // Register writes; a one-shot write wins over the sequencer's clear
    if (wr && st_reg.seq != therm_pkg::S_LOAD) begin
      if (addr == therm_pkg::CFG_ADDR) begin
        st_next.cfg.shutdown_select = wdata[therm_pkg::CFG_SD_BIT];
        st_next.cfg.thermostat_mode_select = wdata[therm_pkg::CFG_MODE_BIT];
        st_next.cfg.alarm_active_level = wdata[therm_pkg::CFG_POL_BIT];
        st_next.cfg.fault_queue_sel_lsb = wdata[therm_pkg::CFG_FQ_LSB_BIT];
        st_next.cfg.fault_queue_sel_msb = wdata[therm_pkg::CFG_FQ_MSB_BIT];
        if (wdata[therm_pkg::CFG_OS_BIT] && wdata[therm_pkg::CFG_SD_BIT]) begin
          st_next.os_pend = 1'b1;
        end
      end else if (addr == therm_pkg::TLOW_ADDR) begin
        st_next.tlow = wdata;
      end else if (addr == therm_pkg::THIGH_ADDR) begin
        st_next.thigh = wdata;
      end
    end

    // Register reads; unmapped addresses read zero
    if (rd) begin
      if (addr == therm_pkg::TEMP_ADDR) begin
        st_next.rdata = st_reg.temp;
      end else if (addr == therm_pkg::CFG_ADDR) begin
        st_next.rdata[therm_pkg::CFG_SD_BIT] = st_reg.cfg.shutdown_select;
        st_next.rdata[therm_pkg::CFG_MODE_BIT] = st_reg.cfg.thermostat_mode_select;
        st_next.rdata[therm_pkg::CFG_POL_BIT] = st_reg.cfg.alarm_active_level;
        st_next.rdata[therm_pkg::CFG_FQ_LSB_BIT] = st_reg.cfg.fault_queue_sel_lsb;
        st_next.rdata[therm_pkg::CFG_FQ_MSB_BIT] = st_reg.cfg.fault_queue_sel_msb;
        st_next.rdata[therm_pkg::CFG_OS_BIT] = st_reg.os_pend;
      end else if (addr == therm_pkg::TLOW_ADDR) begin
        st_next.rdata = st_reg.tlow;
      end else if (addr == therm_pkg::THIGH_ADDR) begin
        st_next.rdata = st_reg.thigh;
      end else if (addr == therm_pkg::STAT_ADDR) begin
        st_next.rdata = therm_pkg::DATA_W'({fq_count, st_reg.armed_low, st_reg.active});
      end
    end

    // Alarm state. Read, alert-ack, shutdown and pulse-end clears come first so a same-cycle event still sets; general call reset comes last.
    if (fq_v.done) begin
      st_next.last_vhigh = fq_v.valid_high;
      st_next.last_vlow = fq_v.valid_low;
    end
    if (int_mode) begin
      if (rd || ara_ack || sd_rise) begin
        st_next.active = 1'b0;
      end
      if (st_reg.pulse_cnt != '0) begin
        st_next.pulse_cnt = st_reg.pulse_cnt - PULSE_ONE;
        if (st_reg.pulse_cnt == PULSE_ONE) begin
          st_next.active = 1'b0;
        end
      end
      // Leaving shutdown replays a pending event only if it is the armed one
      if (sd_fall && !st_reg.active) begin
        if (!st_reg.armed_low && st_reg.last_vhigh) begin
          st_next.active = 1'b1;
          st_next.armed_low = 1'b1;
        end else if (st_reg.armed_low && st_reg.last_vlow) begin
          st_next.active = 1'b1;
          st_next.armed_low = 1'b0;
        end
      end
      if (fq_v.done) begin
        // Lower events are ignored until an upper event has fired
        if (!st_reg.armed_low && fq_v.valid_high) begin
          set_ev = 1'b1;
          st_next.armed_low = 1'b1;
        end else if (st_reg.armed_low && fq_v.valid_low) begin
          set_ev = 1'b1;
          st_next.armed_low = 1'b0;
        end
        if (set_ev) begin
          st_next.active = 1'b1;
          st_next.pulse_cnt = st_reg.single ? PULSE_LOAD : '0;
        end
      end
    end else begin
      // Comparator level moves only on valid faults, so an active alarm
      // carried over from interrupt mode waits for a low fault
      st_next.pulse_cnt = '0;
      if (fq_v.done && fq_v.valid_high) begin
        st_next.active = 1'b1;
      end else if (fq_v.done && fq_v.valid_low) begin
        st_next.active = 1'b0;
      end
      st_next.armed_low = st_next.active;
    end

    if (gc_reset) begin
      st_next.active = 1'b0;
      st_next.pulse_cnt = '0;
      st_next.seq = therm_pkg::S_LOAD;
    end

    // Pin level uses the polarity in force next cycle
    st_next.alarm_pin = st_next.cfg.alarm_active_level ? st_next.active
                      : !st_next.active;
  end

  ////////////////////////////////////////////////////////////////////////////

  // All-zero state starts in S_LOAD with the pin low until the first load
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdata = st_reg.rdata;
  assign conv_start = st_reg.conv_start;
  assign alarm_pin = st_reg.alarm_pin;

  ////////////////////////////////////////////////////////////////////////////

  nv_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_reg.seq == therm_pkg::S_LOAD && !gc_reset && !wr |=>
      st_reg.cfg.thermostat_mode_select == $past(nv_config[therm_pkg::CFG_MODE_BIT])
      && st_reg.cfg.alarm_active_level == $past(nv_config[therm_pkg::CFG_POL_BIT])
      && st_reg.seq == therm_pkg::S_IDLE)
    else $error("nonvolatile settings not loaded");

  pin_level_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_reg.seq != therm_pkg::S_LOAD |->
      alarm_pin == (st_reg.cfg.alarm_active_level ~^ st_reg.active))
    else $error("alarm pin polarity wrong");

  cmp_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    !int_mode && fq_v.valid_high && !gc_reset |=> st_reg.active)
    else $error("comparator alarm not set by upper fault");

  cmp_clear_a: assert property (@(posedge mclk) disable iff (!resetn)
    !int_mode && fq_v.valid_low && !fq_v.valid_high |=> !st_reg.active)
    else $error("comparator alarm not released by lower fault");

  cmp_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !int_mode && !fq_v.done && !gc_reset && st_reg.seq != therm_pkg::S_LOAD
      |=> st_reg.active == $past(st_reg.active))
    else $error("comparator alarm moved without a valid fault");

  int_read_clr_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && (rd || ara_ack) && !fq_v.done && !sd_fall && st_reg.pulse_cnt == '0
      |=> !st_reg.active)
    else $error("interrupt alarm not cleared by read or alert ack");

  int_first_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && !st_reg.active && !st_reg.armed_low && !sd_fall
      && fq_v.done && !fq_v.valid_high |=> !st_reg.active)
    else $error("interrupt alarm set without upper event");

  sd_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && sd_rise && !fq_v.done |=> !st_reg.active)
    else $error("shutdown entry did not clear interrupt alarm");

  sd_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_reg.seq == therm_pkg::S_IDLE && st_reg.cfg.shutdown_select
      && !st_reg.boot_once && !st_reg.os_pend |=> !conv_start)
    else $error("conversion started while shut down");

  gc_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
    gc_reset |=> st_reg.seq == therm_pkg::S_LOAD && !st_reg.active)
    else $error("general call reset not honoured");

  pulse_end_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && st_reg.pulse_cnt == PULSE_ONE && !fq_v.done && !sd_fall
      |=> !st_reg.active)
    else $error("one-shot interrupt pulse did not end");

  pulse_bound_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(st_reg.pulse_cnt != '0) |-> ##[1:PULSE_MAX_A] st_reg.pulse_cnt == '0)
    else $error("one-shot pulse too long");

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and alarm bookkeeping; these guard paths the bench seldom hits

  cmp_keep_a: assert property (@(posedge mclk) disable iff (!resetn)
    !int_mode && st_reg.active && !fq_v.valid_low && !gc_reset |=> st_reg.active)
    else $error("comparator alarm dropped without a lower fault");

  int_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && st_reg.active && !rd && !ara_ack && !sd_rise && !gc_reset
      && st_reg.pulse_cnt == '0 |=> st_reg.active)
    else $error("interrupt alarm dropped without a clearing event");

  int_set_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && !st_reg.armed_low && fq_v.valid_high && !gc_reset
      |=> st_reg.active && st_reg.armed_low)
    else $error("interrupt alarm not armed by upper event");

  int_alt_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && st_reg.armed_low && !st_reg.active && fq_v.valid_high && !sd_fall
      |=> !st_reg.active)
    else $error("upper event fired while lower event armed");

  sd_replay_a: assert property (@(posedge mclk) disable iff (!resetn)
    int_mode && sd_fall && !st_reg.active && st_reg.armed_low && st_reg.last_vlow
      && !gc_reset |=> st_reg.active)
    else $error("pending armed event not replayed on shutdown exit");

  boot_conv_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_reg.seq == therm_pkg::S_IDLE && st_reg.boot_once && !gc_reset
      |=> st_reg.conv_start && st_reg.single)
    else $error("boot reading not started");

  os_conv_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_reg.seq == therm_pkg::S_IDLE && st_reg.os_pend && !gc_reset |=> st_reg.conv_start)
    else $error("one-shot reading not started");

  run_conv_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_reg.seq == therm_pkg::S_IDLE && !st_reg.cfg.shutdown_select && !gc_reset
      |=> st_reg.conv_start)
    else $error("continuous conversion not restarted");

  conv_pulse_a: assert property (@(posedge mclk) disable iff (!resetn)
    st_reg.conv_start |=> !st_reg.conv_start)
    else $error("conversion start longer than one cycle");

  temp_store_a: assert property (@(posedge mclk) disable iff (!resetn)
    sample |=> st_reg.temp == $past(conv_result))
    else $error("fresh result not stored");

  verdict_due_a: assert property (@(posedge mclk) disable iff (!resetn)
    sample && !gc_reset |=> fq_v.done)
    else $error("stored result not compared");

  rdata_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    !rd |=> rdata == '0)
    else $error("read data stood without a read");

endmodule : temp_alarm_thermostat

// >>> tb/conv_model.sv
// Behavioural converter: answers each start pulse with one result.
`timescale 1ns/1ns
module conv_model #(
  parameter int LAT = 4
) (
  input wire logic mclk,
  input wire logic conv_start,
  input wire logic [therm_pkg::DATA_W-1:0] temp_val,
  output logic conv_done,
  output logic [therm_pkg::DATA_W-1:0] conv_result
);
  int wait_cnt = 0;
  initial begin
    conv_done = 1'b0;
    conv_result = 16'h0000;
  end
  // Result toggles outside the done cycle so a late sample never looks valid
  always @(posedge mclk) begin
    conv_done <= (wait_cnt == 1);
    if (wait_cnt == 1) begin
      conv_result <= temp_val;
    end else begin
      conv_result <= ~conv_result;
    end
    if (conv_start === 1'b1) begin
      wait_cnt <= LAT;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : conv_model

// >>> tb/tb_temp_alarm_thermostat.sv
// Self-checking bench for the thermostat alarm block.
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, (a), (b)); end end
module tb_temp_alarm_thermostat;
  localparam int PULSE = 2;
  localparam logic [15:0] LO = 16'h0100;
  localparam logic [15:0] MID = 16'h0180;
  localparam logic [15:0] HI = 16'h0200;
  logic mclk = 1'b0;
  logic resetn;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [15:0] nv_config;
  logic [15:0] nv_tlow;
  logic [15:0] nv_thigh;
  logic conv_start;
  logic conv_done;
  logic [15:0] conv_result;
  logic gc_reset;
  logic ara_ack;
  logic alarm_pin;
  logic [15:0] tv;
  logic [15:0] v;
  int err_count = 0;
  int checked = 0;
  int starts = 0;
  int highs = 0;
  int depth [4] = '{1, 2, 4, 6};

  always #20 mclk = ~mclk;

  temp_alarm_thermostat #(.PULSE_CYCLES(PULSE)) uut (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .nv_config(nv_config), .nv_tlow(nv_tlow), .nv_thigh(nv_thigh),
    .conv_start(conv_start), .conv_done(conv_done), .conv_result(conv_result),
    .gc_reset(gc_reset), .ara_ack(ara_ack), .alarm_pin(alarm_pin)
  );
  conv_model #(.LAT(4)) u_conv (
    .mclk(mclk), .conv_start(conv_start), .temp_val(tv),
    .conv_done(conv_done), .conv_result(conv_result)
  );

  always @(posedge mclk) begin
    if (conv_start === 1'b1) starts++;
    if (alarm_pin === 1'b1) highs++;
  end

  ////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // Extra edge so a result already in flight never carries the old value
  task set_t(input logic [15:0] t);
    @(posedge mclk);
    tv <= t;
    @(posedge mclk);
  endtask : set_t

  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  task conv(input int n);
    int t;
    repeat (n) begin
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (conv_done !== 1'b1 && t < 100);
      if (t >= 100) `CHK(conv_done, 1'b1)
    end
    settle();
  endtask : conv

  task gc_pulse(input logic [15:0] nv);
    @(posedge mclk);
    nv_config <= nv;
    gc_reset <= 1'b1;
    @(posedge mclk);
    gc_reset <= 1'b0;
    settle();
  endtask : gc_pulse

  task ara_pulse;
    @(posedge mclk);
    ara_ack <= 1'b1;
    @(posedge mclk);
    ara_ack <= 1'b0;
    #1;
  endtask : ara_pulse

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    gc_reset = 1'b0;
    ara_ack = 1'b0;
    tv = MID;
    nv_config = 16'h000C;
    nv_tlow = LO;
    nv_thigh = HI;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    settle();
    `CHK(alarm_pin, 1'b0)
    rd_reg(therm_pkg::CFG_ADDR, v);
    `CHK(v, 16'h000C)
    rd_reg(8'h3F, v);
    `CHK(v, 16'h0000)
    // Comparator mode, every queue code
    for (int q = 0; q < 4; q++) begin
      wr_reg(therm_pkg::CFG_ADDR, 16'h0004 | 16'(q << 3));
      set_t(LO);
      conv(6);
      set_t(MID);
      conv(1);
      `CHK(alarm_pin, 1'b0)
      set_t(HI);
      if (depth[q] > 1) begin
        conv(depth[q] - 1);
        set_t(MID);
        conv(1);
        set_t(HI);
      end
      for (int k = 1; k <= depth[q]; k++) begin
        conv(1);
        `CHK(alarm_pin, k == depth[q])
      end
    end
    rd_reg(therm_pkg::TEMP_ADDR, v);
    `CHK(v, HI)
    wr_reg(therm_pkg::TLOW_ADDR, LO);
    settle();
    `CHK(alarm_pin, 1'b1)
    // Interrupt mode, queue of one
    gc_pulse(16'h0006);
    `CHK(alarm_pin, 1'b0)
    set_t(LO);
    conv(2);
    `CHK(alarm_pin, 1'b0)
    set_t(HI);
    conv(1);
    `CHK(alarm_pin, 1'b1)
    conv(2);
    `CHK(alarm_pin, 1'b1)
    rd_reg(therm_pkg::TEMP_ADDR, v);
    `CHK(alarm_pin, 1'b0)
    conv(2);
    `CHK(alarm_pin, 1'b0)
    set_t(LO);
    conv(1);
    `CHK(alarm_pin, 1'b1)
    ara_pulse();
    `CHK(alarm_pin, 1'b0)
    set_t(HI);
    conv(1);
    `CHK(alarm_pin, 1'b1)
    wr_reg(therm_pkg::CFG_ADDR, 16'h0007);
    settle();
    `CHK(alarm_pin, 1'b0)
    repeat (20) @(posedge mclk);
    starts = 0;
    repeat (40) @(posedge mclk);
    `CHK(starts, 0)
    // One-shot while shut down, lower event is the armed one
    set_t(LO);
    starts = 0;
    highs = 0;
    wr_reg(therm_pkg::CFG_ADDR, 16'h0087);
    repeat (40) @(posedge mclk);
    `CHK(starts, 1)
    `CHK(highs, PULSE)
    // Reload with active-low polarity, comparator, continuous
    gc_pulse(16'h0000);
    `CHK(alarm_pin, 1'b1)
    rd_reg(therm_pkg::CFG_ADDR, v);
    `CHK(v, 16'h0000)
    set_t(HI);
    conv(1);
    `CHK(alarm_pin, 1'b0)
    tally_and_finish();
  end
endmodule : tb_temp_alarm_thermostat
